// [idm_pkg.sv]
// Constants shared by the destination-match and local vector logic.
// Assumes a 4 KB register window addressed by byte offset.
package idm_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_UNIT_ID = 12'h020;
  localparam logic [11:0] OFS_LOGICAL_DEST = 12'h0d0;
  localparam logic [11:0] OFS_DEST_FORMAT = 12'h0e0;
  localparam logic [11:0] OFS_ENTRY_TIMER = 12'h320;
  localparam logic [11:0] OFS_ENTRY_PIN0 = 12'h350;
  localparam logic [11:0] OFS_ENTRY_PIN1 = 12'h360;
  localparam logic [11:0] OFS_ENTRY_ERROR = 12'h370;
  // Field positions
  localparam int UNIT_ID_LSB = 24;
  localparam int LOGICAL_ID_LSB = 24;
  localparam int FORMAT_LSB = 28;
  localparam int ENT_DLV_LSB = 8;
  localparam int ENT_STATUS = 12;
  localparam int ENT_POLARITY = 13;
  localparam int ENT_TRIGGER = 15;
  localparam int ENT_MASK = 16;
  localparam int ENT_TIMER_MODE = 17;
  // Reset values and fixed patterns
  localparam logic [3:0] FORMAT_FLAT = 4'hf;
  localparam logic [3:0] FORMAT_CLUSTER = 4'h0;
  localparam logic [3:0] PHYS_BROADCAST = 4'hf;
  localparam logic [7:0] LOGICAL_BROADCAST = 8'hff;
  localparam logic [27:0] FORMAT_LOW_READ = 28'hfffffff;
  localparam logic [31:0] ENTRY_RESET = 32'h0001_0000;
  // Writable bits per entry kind
  localparam logic [31:0] WMASK_TIMER = 32'h0003_00ff;
  localparam logic [31:0] WMASK_PIN = 32'h0001_a7ff;
  localparam logic [31:0] WMASK_ERROR = 32'h0001_00ff;
  // Entry indices
  localparam logic [1:0] IDX_TIMER = 2'h0;
  localparam logic [1:0] IDX_PIN0 = 2'h1;
  localparam logic [1:0] IDX_PIN1 = 2'h2;
  localparam logic [1:0] IDX_ERROR = 2'h3;
  // Delivery mode encodings
  localparam logic [2:0] DLV_FIXED = 3'h0;
  localparam logic [2:0] DLV_LOWEST = 3'h1;
  localparam logic [2:0] DLV_SMI = 3'h2;
  localparam logic [2:0] DLV_NMI = 3'h4;
  localparam logic [2:0] DLV_INIT = 3'h5;
  localparam logic [2:0] DLV_STARTUP = 3'h6;
  localparam logic [2:0] DLV_EXTERNAL = 3'h7;
  // Cycles after reset release before straps are taken
  localparam logic [1:0] CFG_LOAD_CYC = 2'h3;
  typedef enum logic {ACK_IDLE, ACK_ASK} idm_ack_state_t;
endpackage : idm_pkg

// [idm_dest_match.sv]
// Combinational destination matcher for incoming interrupt messages.
// Assumes register values are stable in the cycle of the message.
`timescale 1ns/100ps
module idm_dest_match
  import idm_pkg::*;
(
  input wire logic logical_mode,
  input wire logic [7:0] message_destination_address,
  input wire logic [3:0] unit_id,
  input wire logic [7:0] logical_id,
  input wire logic [3:0] format,
  output logic hit
);
  logic [7:0] dest;
  assign dest = message_destination_address;

  always_comb
  begin
    hit = 1'b0;
    if (!logical_mode)
    begin
      hit = (dest[3:0] == PHYS_BROADCAST) || (dest[3:0] == unit_id);
    end
    else if (format == FORMAT_FLAT)
    begin
      hit = (dest == LOGICAL_BROADCAST) || ((dest & logical_id) != 8'h00);
    end
    else if (format == FORMAT_CLUSTER)
    begin
      if (dest == LOGICAL_BROADCAST)
      begin
        hit = 1'b1;
      end
      else if (dest[7:4] == logical_id[7:4])
      begin
        hit = (dest[3:0] & logical_id[3:0]) != 4'h0;
      end
    end
  end
endmodule : idm_dest_match

// [idm_pin_sense.sv]
// Sensing of one local interrupt pin as set by its vector table entry.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/100ps
module idm_pin_sense
  import idm_pkg::*;
#(
  parameter bit HAS_IO_UNIT = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic pin_raw,
  input wire logic [31:0] entry,
  output logic fixed_req,
  output logic nmi_pulse,
  output logic ext_req,
  output logic pending
);
  logic sync_a;
  logic sync_b;
  logic prev_active;
  logic active;
  logic rise;
  logic masked;
  logic level_mode;
  logic [2:0] mode;

  assign active = sync_b ^ entry[ENT_POLARITY];
  assign rise = active && !prev_active;
  assign masked = entry[ENT_MASK];
  assign mode = entry[ENT_DLV_LSB +: 3];
  // Fixed mode without an I/O unit is forced to level sensing
  assign level_mode = entry[ENT_TRIGGER] || !HAS_IO_UNIT;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev_active <= 1'b0;
    end
    else
    begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
      prev_active <= active;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      fixed_req <= 1'b0;
      nmi_pulse <= 1'b0;
      ext_req <= 1'b0;
    end
    else
    begin
      fixed_req <= (mode == DLV_FIXED) && !masked && (level_mode ? active : rise);
      nmi_pulse <= (mode == DLV_NMI) && !masked && rise;
      ext_req <= (mode == DLV_EXTERNAL) && !masked && active;
    end
  end

  assign pending = fixed_req || nmi_pulse || ext_req;
endmodule : idm_pin_sense

// [idm_top.sv]
// Local interrupt unit: destination match, arbitration priority,
// delivery choice and local vector table.
// Assumes message, arbitration and core inputs are on clk_sys;
// strap and local pins are asynchronous.
`timescale 1ns/100ps
module idm_top
  import idm_pkg::*;
#(
  parameter bit HAS_IO_UNIT = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic config_addr_line_a_n,
  input wire logic config_addr_line_b_n,
  input wire logic [3:0] bus_request_line_n,
  input wire logic msg_valid,
  input wire logic msg_logical,
  input wire logic [7:0] message_destination_address,
  input wire logic [2:0] msg_mode,
  input wire logic [7:0] msg_vector,
  input wire logic msg_focus,
  input wire logic msg_init_deassert,
  input wire logic [7:0] priority_compare_reg,
  input wire logic peer_valid,
  input wire logic [7:0] peer_priority,
  input wire logic [3:0] peer_priority_id,
  output logic msg_accept,
  output logic [7:0] acc_vector,
  output logic [2:0] acc_mode,
  input wire logic arb_request,
  input wire logic arb_round,
  input wire logic [3:0] arb_peer_max,
  output logic arb_win,
  output logic [3:0] arbitration_priority_id,
  input wire logic timer_event,
  input wire logic error_event,
  output logic timer_irq,
  output logic error_irq,
  output logic [7:0] timer_vector,
  output logic [7:0] error_vector,
  input wire logic local_pin_0,
  input wire logic local_pin_1,
  output logic [1:0] pin_fixed_req,
  output logic [1:0] pin_nmi,
  output logic [15:0] pin_vector,
  output logic ack_req,
  input wire logic ack_done,
  input wire logic [7:0] ack_vector,
  output logic ext_vector_valid,
  output logic [7:0] ext_vector
);
  logic [3:0] unit_id;
  logic [7:0] logical_id;
  logic [3:0] dest_format;
  logic [31:0] entry [4];
  logic [1:0] cfg_cnt;
  logic cfg_done;
  logic [5:0] strap_a;
  logic [5:0] strap_b;
  logic [3:0] strap_id;
  logic wr_id;
  logic wr_logical;
  logic wr_format;
  logic ent_hit;
  logic [1:0] ent_idx;
  logic [31:0] ent_wmask;
  logic [31:0] next_rdata;
  logic dm_hit;
  logic is_static;
  logic lp_win;
  logic take;
  logic [1:0] pin_ext;
  logic [1:0] pin_pend;
  logic [1:0] pin_raw;
  idm_ack_state_t ack_state;

  // Strap synchroniser; first stage feeds only the second
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      strap_a <= 6'h00;
      strap_b <= 6'h00;
    end
    else
    begin
      strap_a <= ~{config_addr_line_b_n, config_addr_line_a_n, bus_request_line_n};
      strap_b <= strap_a;
    end
  end

  // Agent number from the active request line, cluster from the address lines
  always_comb
  begin
    strap_id[3:2] = strap_b[5:4];
    strap_id[1:0] = 2'h0;
    if (strap_b[3])
    begin
      strap_id[1:0] = 2'h3;
    end
    else if (strap_b[2])
    begin
      strap_id[1:0] = 2'h2;
    end
    else if (strap_b[1])
    begin
      strap_id[1:0] = 2'h1;
    end
  end

  // Straps are taken once, after the synchroniser has filled
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cfg_cnt <= 2'h0;
    end
    else if (!cfg_done)
    begin
      cfg_cnt <= cfg_cnt + 2'h1;
    end
  end

  assign cfg_done = (cfg_cnt == CFG_LOAD_CYC);

  // Register decode
  assign wr_id = reg_wr && (reg_addr == OFS_UNIT_ID);
  assign wr_logical = reg_wr && (reg_addr == OFS_LOGICAL_DEST);
  assign wr_format = reg_wr && (reg_addr == OFS_DEST_FORMAT);

  always_comb
  begin
    ent_hit = 1'b1;
    ent_idx = IDX_TIMER;
    ent_wmask = WMASK_TIMER;
    case (reg_addr)
      OFS_ENTRY_TIMER:
      begin
        ent_idx = IDX_TIMER;
        ent_wmask = WMASK_TIMER;
      end
      OFS_ENTRY_PIN0:
      begin
        ent_idx = IDX_PIN0;
        ent_wmask = WMASK_PIN;
      end
      OFS_ENTRY_PIN1:
      begin
        ent_idx = IDX_PIN1;
        ent_wmask = WMASK_PIN;
      end
      OFS_ENTRY_ERROR:
      begin
        ent_idx = IDX_ERROR;
        ent_wmask = WMASK_ERROR;
      end
      default:
      begin
        ent_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      unit_id <= 4'h0;
    end
    else if (cfg_cnt == CFG_LOAD_CYC - 2'h1)
    begin
      unit_id <= strap_id;
    end
    else if (wr_id && cfg_done)
    begin
      unit_id <= reg_wdata[UNIT_ID_LSB +: 4];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      logical_id <= 8'h00;
    end
    else if (wr_logical)
    begin
      logical_id <= reg_wdata[LOGICAL_ID_LSB +: 8];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      dest_format <= FORMAT_FLAT;
    end
    else if (wr_format)
    begin
      dest_format <= reg_wdata[FORMAT_LSB +: 4];
    end
  end

  // Vector table; read-only and absent fields never store
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        entry[i] <= ENTRY_RESET;
      end
    end
    else if (reg_wr && ent_hit)
    begin
      entry[ent_idx] <= reg_wdata & ent_wmask;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (reg_addr)
      OFS_UNIT_ID:
      begin
        next_rdata[UNIT_ID_LSB +: 4] = unit_id;
      end
      OFS_LOGICAL_DEST:
      begin
        next_rdata[LOGICAL_ID_LSB +: 8] = logical_id;
      end
      OFS_DEST_FORMAT:
      begin
        next_rdata = {dest_format, FORMAT_LOW_READ};
      end
      OFS_ENTRY_TIMER:
      begin
        next_rdata = entry[IDX_TIMER];
      end
      OFS_ENTRY_PIN0:
      begin
        next_rdata = entry[IDX_PIN0];
        next_rdata[ENT_STATUS] = pin_pend[0];
      end
      OFS_ENTRY_PIN1:
      begin
        next_rdata = entry[IDX_PIN1];
        next_rdata[ENT_STATUS] = pin_pend[1];
      end
      OFS_ENTRY_ERROR:
      begin
        next_rdata = entry[IDX_ERROR];
      end
      default:
      begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        reg_rdata <= next_rdata;
      end
    end
  end

  idm_dest_match i_idm_dest_match (
    .logical_mode(msg_logical),
    .message_destination_address(message_destination_address),
    .unit_id(unit_id),
    .logical_id(logical_id),
    .format(dest_format),
    .hit(dm_hit)
  );

  // Static modes; reserved encoding is never taken
  always_comb
  begin
    case (msg_mode)
      DLV_FIXED, DLV_SMI, DLV_NMI, DLV_INIT, DLV_STARTUP, DLV_EXTERNAL:
      begin
        is_static = 1'b1;
      end
      default:
      begin
        is_static = 1'b0;
      end
    endcase
  end

  // Peer figures are the best of the other matching units
  assign lp_win = msg_focus
    || !peer_valid
    || (priority_compare_reg < peer_priority)
    || ((priority_compare_reg == peer_priority)
        && (arbitration_priority_id > peer_priority_id));

  assign take = msg_valid && dm_hit
    && ((msg_mode == DLV_LOWEST) ? lp_win : is_static);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      msg_accept <= 1'b0;
      acc_vector <= 8'h00;
      acc_mode <= DLV_FIXED;
    end
    else
    begin
      msg_accept <= take;
      // A miss leaves the last accepted message in place
      if (take)
      begin
        acc_vector <= msg_vector;
        acc_mode <= msg_mode;
      end
    end
  end

  // Arbitration priority, invisible to software
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      arbitration_priority_id <= 4'h0;
      arb_win <= 1'b0;
    end
    else
    begin
      arb_win <= arb_round && arb_request && (arbitration_priority_id > arb_peer_max);
      if (cfg_cnt == CFG_LOAD_CYC - 2'h1)
      begin
        arbitration_priority_id <= strap_id;
      end
      else if (msg_init_deassert)
      begin
        arbitration_priority_id <= unit_id;
      end
      else if (arb_round && arb_request)
      begin
        if (arbitration_priority_id > arb_peer_max)
        begin
          arbitration_priority_id <= 4'h0;
        end
        else
        begin
          arbitration_priority_id <= arbitration_priority_id + 4'h1;
        end
      end
    end
  end

  // Timer and error sources: edge only, vector always used
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      timer_irq <= 1'b0;
      error_irq <= 1'b0;
      timer_vector <= 8'h00;
      error_vector <= 8'h00;
    end
    else
    begin
      timer_irq <= timer_event && !entry[IDX_TIMER][ENT_MASK];
      error_irq <= error_event && !entry[IDX_ERROR][ENT_MASK];
      timer_vector <= entry[IDX_TIMER][7:0];
      error_vector <= entry[IDX_ERROR][7:0];
    end
  end

  assign pin_raw = {local_pin_1, local_pin_0};

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_pin
      idm_pin_sense #(
        .HAS_IO_UNIT(HAS_IO_UNIT)
      ) i_idm_pin_sense (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_raw(pin_raw[g]),
        .entry(entry[g + 1]),
        .fixed_req(pin_fixed_req[g]),
        .nmi_pulse(pin_nmi[g]),
        .ext_req(pin_ext[g]),
        .pending(pin_pend[g])
      );

      always_ff @(posedge clk_sys)
      begin
        if (sys_rst)
        begin
          pin_vector[g * 8 +: 8] <= 8'h00;
        end
        else
        begin
          pin_vector[g * 8 +: 8] <= entry[g + 1][7:0];
        end
      end
    end
  endgenerate

  // Acknowledge cycle; one external source assumed, so pins share it
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ack_state <= ACK_IDLE;
      ext_vector_valid <= 1'b0;
      ext_vector <= 8'h00;
    end
    else
    begin
      ext_vector_valid <= 1'b0;
      case (ack_state)
        ACK_IDLE:
        begin
          if (pin_ext != 2'b00)
          begin
            ack_state <= ACK_ASK;
          end
        end
        ACK_ASK:
        begin
          if (ack_done)
          begin
            ext_vector <= ack_vector;
            ext_vector_valid <= 1'b1;
            ack_state <= ACK_IDLE;
          end
        end
        default:
        begin
          ack_state <= ACK_IDLE;
        end
      endcase
    end
  end

  assign ack_req = (ack_state == ACK_ASK);
endmodule : idm_top

// [idm_chk.sv]
// Port-level checker for idm_top.
// Bound to every idm_top; sees only the top module's ports.
`timescale 1ns/100ps
module idm_chk
  import idm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic msg_valid,
  input wire logic msg_logical,
  input wire logic [7:0] message_destination_address,
  input wire logic [2:0] msg_mode,
  input wire logic msg_focus,
  input wire logic msg_init_deassert,
  input wire logic [7:0] priority_compare_reg,
  input wire logic peer_valid,
  input wire logic [7:0] peer_priority,
  input wire logic [3:0] peer_priority_id,
  input wire logic msg_accept,
  input wire logic arb_request,
  input wire logic arb_round,
  input wire logic [3:0] arb_peer_max,
  input wire logic arb_win,
  input wire logic [3:0] arbitration_priority_id,
  input wire logic timer_event,
  input wire logic timer_irq,
  input wire logic ack_req,
  input wire logic ack_done
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  property p_cause;
    msg_accept |-> $past(msg_valid);
  endproperty
  a_cause: assert property (p_cause) else $error("accept without message");
  property p_bcast;
    msg_valid && !msg_logical && message_destination_address[3:0] == 4'hf
      && msg_mode == DLV_FIXED |=> msg_accept;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast not taken");
  // Lowest-priority loss: a busier unit without focus stays out
  property p_lose;
    msg_valid && msg_mode == DLV_LOWEST && peer_valid && !msg_focus
      && priority_compare_reg > peer_priority |=> !msg_accept;
  endproperty
  a_lose: assert property (p_lose) else $error("lowest loss accepted");
  property p_tie;
    msg_valid && msg_mode == DLV_LOWEST && peer_valid && !msg_focus
      && priority_compare_reg == peer_priority
      && arbitration_priority_id < peer_priority_id |=> !msg_accept;
  endproperty
  a_tie: assert property (p_tie) else $error("tie taken by lower id");
  property p_win;
    arb_round && arb_request && !msg_init_deassert
      |=> arb_win == ($past(arbitration_priority_id) > $past(arb_peer_max));
  endproperty
  a_win: assert property (p_win) else $error("wrong round winner");
  property p_step;
    arb_round && arb_request && !msg_init_deassert && arbitration_priority_id <= arb_peer_max
      |=> arbitration_priority_id == $past(arbitration_priority_id) + 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("loser did not step");
  property p_timer;
    timer_irq |-> $past(timer_event);
  endproperty
  a_timer: assert property (p_timer) else $error("timer irq without event");
  property p_hold;
    ack_req && !ack_done |=> ack_req;
  endproperty
  a_hold: assert property (p_hold) else $error("acknowledge dropped early");
  c_win: cover property (arb_win);
  c_acc: cover property (msg_accept);
  c_ack: cover property (ack_req && ack_done);
endmodule : idm_chk

bind idm_top idm_chk i_idm_chk (.*);

// [idm_ext_ctl.sv]
// Model of the external legacy controller answering acknowledge cycles.
// Assumes ack_req comes from idm_top on the shared clk_sys.
`timescale 1ns/100ps
module idm_ext_ctl
#(
  parameter logic [3:0] DELAY = 4'h2,
  parameter logic [7:0] VEC = 8'h5a
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ack_req,
  output logic ack_done,
  output logic [7:0] ack_vector
);
  logic [3:0] wait_cnt;

  // Sole external-mode source in the system
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wait_cnt <= 4'h0;
      ack_done <= 1'b0;
      ack_vector <= 8'h00;
    end
    else if (ack_req && !ack_done && wait_cnt == DELAY)
    begin
      ack_done <= 1'b1;
      ack_vector <= VEC;
    end
    else
    begin
      // Vector lines released: keep them moving, never the last value
      wait_cnt <= (ack_req && !ack_done) ? wait_cnt + 4'h1 : 4'h0;
      ack_done <= 1'b0;
      ack_vector <= ~ack_vector;
    end
  end
endmodule : idm_ext_ctl

// [idm_top_tb.sv]
// Self-checking bench for idm_top with the legacy controller model.
// Assumes the strap pins stay fixed: unit identifier loads as 6.
`timescale 1ns/100ps
module idm_top_tb;
  import idm_pkg::*;
  logic clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, msg_valid = 1'b0;
  logic msg_logical = 1'b0, msg_focus = 1'b0, msg_init_deassert = 1'b0, peer_valid = 1'b0;
  logic arb_request = 1'b0, arb_round = 1'b0, timer_event = 1'b0, error_event = 1'b0;
  logic local_pin_0 = 1'b0, local_pin_1 = 1'b1;
  logic config_addr_line_a_n = 1'b0, config_addr_line_b_n = 1'b1;
  logic [3:0] bus_request_line_n = 4'hb, peer_priority_id = 4'h0, arb_peer_max = 4'h0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [7:0] message_destination_address = 8'h00, msg_vector = 8'h00;
  logic [7:0] priority_compare_reg = 8'h00, peer_priority = 8'h00, last_v = 8'h00;
  logic [7:0] acc_vector, timer_vector, error_vector, ack_vector, ext_vector;
  logic [2:0] msg_mode = 3'h0, acc_mode, last_m = 3'h0;
  logic [1:0] pin_fixed_req, pin_nmi;
  logic [15:0] pin_vector;
  logic [3:0] arbitration_priority_id;
  logic reg_rvalid, msg_accept, arb_win, timer_irq, error_irq, ack_req, ack_done;
  logic ext_vector_valid;
  int n_mismatch = 0;
  int compares = 0;

  idm_top i_idm_top (.*);
  idm_ext_ctl i_idm_ext_ctl (.*);

  always #2.5 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk("rvalid", reg_rvalid, 32'h1);
    chk("rdata", reg_rdata, exp);
  endtask : rd

  // Vector must stay put on a miss
  task automatic msg(input logic lg, input logic [7:0] d, input logic [2:0] m,
                     input logic [7:0] v, input logic exp);
    @(negedge clk_sys);
    msg_logical = lg;
    message_destination_address = d;
    msg_mode = m;
    msg_vector = v;
    msg_valid = 1'b1;
    @(negedge clk_sys);
    msg_valid = 1'b0;
    if (exp)
    begin
      last_v = v;
      last_m = m;
    end
    chk("accept", msg_accept, exp);
    chk("acc vector", acc_vector, last_v);
    chk("acc mode", acc_mode, last_m);
  endtask : msg

  task automatic round(input logic [3:0] pm, input logic w, input logic [3:0] id);
    @(negedge clk_sys);
    arb_request = 1'b1;
    arb_round = 1'b1;
    arb_peer_max = pm;
    @(negedge clk_sys);
    arb_round = 1'b0;
    arb_request = 1'b0;
    chk("win", arb_win, w);
    chk("arbitration_priority_id", arbitration_priority_id, id);
  endtask : round

  task automatic t_regs();
    rd(OFS_UNIT_ID, 32'h0600_0000);
    chk("arbitration_priority_id", arbitration_priority_id, 32'h6);
    wr(OFS_UNIT_ID, 32'h0900_0000);
    rd(OFS_UNIT_ID, 32'h0900_0000);
    rd(OFS_DEST_FORMAT, 32'hffff_ffff);
    rd(OFS_ENTRY_PIN0, 32'h0001_0000);
    rd(12'h030, 32'h0);
    // Offset 12'h340 holds no entry in this unit, so it reads zero like any unmapped offset
    rd(12'h340, 32'h0);
    wr(OFS_LOGICAL_DEST, 32'h24ff_ffff);
    rd(OFS_LOGICAL_DEST, 32'h2400_0000);
  endtask : t_regs

  task automatic t_arb();
    @(negedge clk_sys);
    msg_init_deassert = 1'b1;
    @(negedge clk_sys);
    msg_init_deassert = 1'b0;
    chk("reload", arbitration_priority_id, 32'h9);
    round(4'h3, 1'b1, 4'h0);
    round(4'h5, 1'b0, 4'h1);
    round(4'h1, 1'b0, 4'h2);
  endtask : t_arb

  task automatic t_match();
    logic [2:0] st [5] = '{DLV_FIXED, DLV_SMI, DLV_NMI, DLV_EXTERNAL, DLV_STARTUP};
    msg(1'b0, 8'h09, DLV_FIXED, 8'h31, 1'b1);
    msg(1'b0, 8'h08, DLV_FIXED, 8'h32, 1'b0);
    msg(1'b0, 8'h0f, DLV_FIXED, 8'h33, 1'b1);
    msg(1'b1, 8'h04, DLV_FIXED, 8'h34, 1'b1);
    msg(1'b1, 8'h80, DLV_FIXED, 8'h35, 1'b0);
    msg(1'b1, 8'hff, DLV_FIXED, 8'h36, 1'b1);
    foreach (st[i])
      msg(1'b1, 8'h20, st[i], 8'h40, 1'b1);
    msg(1'b1, 8'h20, 3'h3, 8'h45, 1'b0);
    wr(OFS_DEST_FORMAT, 32'h0);
    wr(OFS_LOGICAL_DEST, 32'h3500_0000);
    msg(1'b1, 8'h31, DLV_FIXED, 8'h41, 1'b1);
    msg(1'b1, 8'h32, DLV_FIXED, 8'h42, 1'b0);
    msg(1'b1, 8'h41, DLV_FIXED, 8'h43, 1'b0);
    msg(1'b1, 8'hff, DLV_FIXED, 8'h44, 1'b1);
  endtask : t_match

  // Own arbitration id is 2 here
  task automatic t_lowest();
    priority_compare_reg = 8'h05;
    peer_valid = 1'b1;
    peer_priority = 8'h03;
    msg(1'b0, 8'h09, DLV_LOWEST, 8'h51, 1'b0);
    peer_priority = 8'h07;
    msg(1'b0, 8'h09, DLV_LOWEST, 8'h52, 1'b1);
    peer_priority = 8'h05;
    peer_priority_id = 4'h3;
    msg(1'b0, 8'h09, DLV_LOWEST, 8'h53, 1'b0);
    peer_priority_id = 4'h1;
    msg(1'b0, 8'h09, DLV_LOWEST, 8'h54, 1'b1);
    peer_priority = 8'h00;
    msg_focus = 1'b1;
    msg(1'b0, 8'h09, DLV_LOWEST, 8'h55, 1'b1);
    msg_focus = 1'b0;
    peer_valid = 1'b0;
  endtask : t_lowest

  task automatic t_local();
    wr(OFS_ENTRY_TIMER, 32'h0000_0741);
    rd(OFS_ENTRY_TIMER, 32'h0000_0041);
    wr(OFS_ENTRY_ERROR, 32'h0001_0042);
    @(negedge clk_sys);
    timer_event = 1'b1;
    error_event = 1'b1;
    @(negedge clk_sys);
    timer_event = 1'b0;
    error_event = 1'b0;
    chk("timer irq", timer_irq, 32'h1);
    chk("timer vec", timer_vector, 32'h41);
    chk("error irq", error_irq, 32'h0);
    chk("error vec", error_vector, 32'h42);
    @(negedge clk_sys);
    chk("timer pulse", timer_irq, 32'h0);
  endtask : t_local

  task automatic t_pins();
    int n;
    n = 0;
    wr(OFS_ENTRY_PIN0, 32'h0000_0033);
    wr(OFS_ENTRY_PIN1, 32'h0000_2400);
    local_pin_0 = 1'b1;
    local_pin_1 = 1'b0;
    repeat (8)
    begin
      @(negedge clk_sys);
      n = n + pin_nmi[1];
    end
    chk("nmi count", n, 32'h1);
    chk("fixed", pin_fixed_req[0], 32'h1);
    chk("pin vec", pin_vector, 32'h0033);
    rd(OFS_ENTRY_PIN0, 32'h0000_1033);
    wr(OFS_ENTRY_PIN0, 32'h0001_0033);
    repeat (2) @(negedge clk_sys);
    chk("masked", pin_fixed_req[0], 32'h0);
    wr(OFS_ENTRY_PIN1, 32'h0000_0700);
    local_pin_1 = 1'b1;
    n = 0;
    while (ext_vector_valid !== 1'b1 && n < 20)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("ext valid", ext_vector_valid, 32'h1);
    chk("ext vec", ext_vector, 32'h5a);
    local_pin_1 = 1'b0;
  endtask : t_pins

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (5) @(negedge clk_sys);
    t_regs();
    t_arb();
    t_match();
    t_lowest();
    t_local();
    t_pins();
    end_of_test();
  end

  // About 120 cycles expected; far longer means a hang
  initial
  begin
    #20000;
    n_mismatch++;
    end_of_test();
  end
endmodule : idm_top_tb
